// ===== src/ddr_bus_cmd_addr_frontend.v
/*
  Device-side front end of a byte-wide DDR memory bus: framing, command/address
  capture and decode, strobe/mask line handling, read and write data words.
  Assumes the bus clock is at most an eighth of clk and stops between frames;
  memory logic behind it feeds read words and drains write words.
*/
`timescale 1ns/1ps
`include "ddr_frontend_consts.vh"

module ddr_bus_cmd_addr_frontend (
   input  wire                    clk,
   input  wire                    rst_n,
   input  wire                    chip_select_n,
   input  wire                    bus_clock_true,
   input  wire                    bus_clock_comp,
   input  wire                    hw_reset_n,
   input  wire [`BYTE_WIDTH-1:0]  dq_in,
   output wire [`BYTE_WIDTH-1:0]  dq_out,
   output wire                    dq_oe,
   input  wire                    strobe_mask_line_in,
   output wire                    strobe_mask_line_out,
   output wire                    strobe_mask_line_oe,
   input  wire                    diff_clock_en,
   input  wire                    refresh_pending,
   input  wire [`LAT_WIDTH-1:0]   latency_count,
   output wire [`CA_WIDTH-1:0]    cmd_addr_bits,
   output wire                    cmd_valid,
   output wire                    access_start,
   output wire                    is_read,
   output wire                    space_select_bit,
   output wire                    linear_burst,
   output wire [`ROW_WIDTH-1:0]   row_upper_addr,
   output wire [`COL_WIDTH-1:0]   start_word,
   output wire [`ADDR_WIDTH-1:0]  word_addr,
   output wire                    page_fetch,
   output wire                    frame_active,
   input  wire [`WORD_WIDTH-1:0]  rd_word,
   input  wire                    rd_valid,
   output wire                    rd_ready,
   output wire [`WORD_WIDTH-1:0]  wr_word,
   output wire [1:0]              wr_byte_en,
   output wire [`ADDR_WIDTH-1:0]  wr_addr,
   output wire                    wr_valid,
   input  wire                    wr_ready,
   output wire                    wr_overrun
);
   // ********************************
   // States
   // ********************************
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_CA    = 5'h02;
   localparam [4:0] ST_LAT   = 5'h04;
   localparam [4:0] ST_READ  = 5'h08;
   localparam [4:0] ST_WRITE = 5'h10;
   localparam WR_W = `WORD_WIDTH + 2 + `ADDR_WIDTH;

   // ********************************
   // Pin synchronisers and edges
   // ********************************
   wire [`PIN_SYNC_WIDTH-1:0] pins_s;
   wire                       cs_n_s;
   wire                       ck_t_s;
   wire                       ck_c_s;
   wire                       hw_rst_n_s;
   wire                       mask_s;
   wire [`BYTE_WIDTH-1:0]     dq_s;
   wire                       ck_level;
   wire                       ck_idle;
   reg                        ck_prev_reg;
   reg                        cs_n_prev_reg;
   wire                       ck_rise;
   wire                       ck_fall;
   wire                       ck_edge;
   wire                       cs_fall;
   wire                       cs_rise;

   pin_sync #(.W(`PIN_SYNC_WIDTH)) u_pin_sync (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    ({chip_select_n, bus_clock_true, bus_clock_comp, hw_reset_n, strobe_mask_line_in, dq_in}),
      .level_out (pins_s)
   );

   assign cs_n_s     = pins_s[12];
   assign ck_t_s     = pins_s[11];
   assign ck_c_s     = pins_s[10];
   assign hw_rst_n_s = pins_s[9];
   assign mask_s     = pins_s[8];
   assign dq_s       = pins_s[7:0];

   // Differential mode needs true and complement to agree
   assign ck_level = diff_clock_en ? (ck_t_s & ~ck_c_s) : ck_t_s;
   assign ck_idle  = ~ck_t_s & (~diff_clock_en | ck_c_s);
   // Work is driven by bus clock and select edges, never by elapsed time
   assign ck_rise  = ck_level & ~ck_prev_reg;
   assign ck_fall  = ~ck_level & ck_prev_reg;
   assign ck_edge  = ck_rise | ck_fall;
   assign cs_fall  = cs_n_prev_reg & ~cs_n_s;
   assign cs_rise  = ~cs_n_prev_reg & cs_n_s;

   // ********************************
   // Buffers
   // ********************************
   wire [`WORD_WIDTH-1:0] rd_buf_data;
   wire                   rd_buf_valid;
   wire                   rd_buf_ready;
   wire                   rd_buf_in_ready;
   wire [WR_W-1:0]        wr_buf_in;
   wire                   wr_buf_in_valid;
   wire                   wr_buf_in_ready;
   wire [WR_W-1:0]        wr_buf_out;

   two_entry_buffer #(.W(`WORD_WIDTH)) u_rd_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (rd_word),
      .in_valid  (rd_valid),
      .in_ready  (rd_buf_in_ready),
      .out_data  (rd_buf_data),
      .out_valid (rd_buf_valid),
      .out_ready (rd_buf_ready)
   );

   two_entry_buffer #(.W(WR_W)) u_wr_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (wr_buf_in),
      .in_valid  (wr_buf_in_valid),
      .in_ready  (wr_buf_in_ready),
      .out_data  (wr_buf_out),
      .out_valid (wr_valid),
      .out_ready (wr_ready)
   );

   assign rd_ready = rd_buf_in_ready;
   assign wr_word    = wr_buf_out[WR_W-1:WR_W-`WORD_WIDTH];
   assign wr_byte_en = wr_buf_out[`ADDR_WIDTH+1:`ADDR_WIDTH];
   assign wr_addr    = wr_buf_out[`ADDR_WIDTH-1:0];

   // ********************************
   // Control registers
   // ********************************
   reg [4:0]                 state_reg;
   reg [2:0]                 edge_cnt_reg;
   reg [`LAT_CNT_WIDTH-1:0]  lat_cnt_reg;
   reg [`LAT_CNT_WIDTH-1:0]  lat_target_reg;
   reg                       extra_lat_reg;
   reg [`CA_WIDTH-1:0]       ca_shift_reg;
   reg [`CA_WIDTH-1:0]       ca_hold_reg;
   reg                       cmd_valid_reg;
   reg                       access_start_reg;
   reg [`ADDR_WIDTH-1:0]     word_addr_reg;
   reg                       page_fetch_reg;
   reg [`WORD_WIDTH-1:0]     rd_hold_reg;
   reg [`BYTE_WIDTH-1:0]     byte_a_reg;
   reg                       mask_a_reg;
   reg                       wr_push_reg;
   reg [WR_W-1:0]            wr_word_reg;
   reg                       wr_overrun_reg;
   reg [`BYTE_WIDTH-1:0]     dq_out_reg;
   reg                       dq_oe_reg;
   reg                       smask_out_reg;
   reg                       smask_oe_reg;
   reg                       rd_pop_reg;
   wire [`ADDR_WIDTH-1:0]    addr_next;
   wire [`LAT_CNT_WIDTH-1:0] target_now;
   wire                      data_read;

   // Extra latency doubles the programmed count
   assign target_now = refresh_pending ? {latency_count, 1'b0}
                                       : {1'b0, latency_count};
   assign data_read  = ca_hold_reg[`CA_RW_BIT];

   // Linear bursts walk on; wrapped ones stay inside the half-page
   assign addr_next = ca_hold_reg[`CA_BURST_BIT] ? (word_addr_reg + `ONE_ADDR)
                    : {word_addr_reg[`ADDR_WIDTH-1:`COL_WIDTH],
                       word_addr_reg[`COL_WIDTH-1:0] + `ONE_EDGE};

   assign rd_buf_ready    = rd_pop_reg;
   assign wr_buf_in       = wr_word_reg;
   assign wr_buf_in_valid = wr_push_reg;

   // ********************************
   // Main sequencer
   // ********************************
   always @(posedge clk) begin
      if (!rst_n || !hw_rst_n_s) begin
         state_reg      <= ST_IDLE;
         edge_cnt_reg   <= `EDGE_CNT_RST;
         lat_cnt_reg    <= `LAT_CNT_RST;
         lat_target_reg <= `LAT_CNT_RST;
         extra_lat_reg  <= 1'b0;
         ca_shift_reg   <= `CA_RST;
         ca_hold_reg    <= `CA_RST;
         cmd_valid_reg  <= 1'b0;
         access_start_reg <= 1'b0;
         word_addr_reg  <= `ADDR_RST;
         page_fetch_reg <= 1'b0;
         rd_hold_reg    <= `WORD_RST;
         byte_a_reg     <= `BYTE_RST;
         mask_a_reg     <= 1'b0;
         wr_push_reg    <= 1'b0;
         wr_word_reg    <= {WR_W{1'b0}};
         wr_overrun_reg <= 1'b0;
         dq_out_reg     <= `BYTE_RST;
         dq_oe_reg      <= 1'b0;
         smask_out_reg  <= 1'b0;
         smask_oe_reg   <= 1'b0;
         rd_pop_reg     <= 1'b0;
         ck_prev_reg    <= 1'b0;
         // Follows the pin during a pin reset, so no false start mid-frame
         cs_n_prev_reg  <= cs_n_s | ~rst_n;
      end else begin
         ck_prev_reg      <= ck_level;
         cs_n_prev_reg    <= cs_n_s;
         cmd_valid_reg    <= 1'b0;
         access_start_reg <= 1'b0;
         page_fetch_reg   <= 1'b0;
         rd_pop_reg       <= 1'b0;
         // Push pulse stays one cycle; a full buffer drops the word and flags it
         wr_push_reg      <= 1'b0;
         if (wr_push_reg && !wr_buf_in_ready) begin
            wr_overrun_reg <= 1'b1;
         end
         if (cs_rise) begin
            state_reg    <= ST_IDLE;
            dq_oe_reg    <= 1'b0;
            smask_oe_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (cs_fall && ck_idle) begin
                     state_reg      <= ST_CA;
                     edge_cnt_reg   <= `EDGE_CNT_RST;
                     extra_lat_reg  <= refresh_pending;
                     lat_target_reg <= target_now;
                     wr_overrun_reg <= wr_push_reg && !wr_buf_in_ready;
                     smask_out_reg  <= refresh_pending;
                     smask_oe_reg   <= 1'b1;
                  end
               end
               ST_CA: begin
                  if (ck_edge) begin
                     ca_shift_reg <= {ca_shift_reg[`CA_WIDTH-`BYTE_WIDTH-1:0], dq_s};
                     edge_cnt_reg <= edge_cnt_reg + `ONE_EDGE;
                     if (edge_cnt_reg + `ONE_EDGE == `CA_ROW_DONE) begin
                        access_start_reg <= 1'b1;
                     end
                     if (edge_cnt_reg + `ONE_EDGE == `CA_BYTE_COUNT) begin
                        ca_hold_reg   <= {ca_shift_reg[`CA_WIDTH-`BYTE_WIDTH-1:0], dq_s};
                        cmd_valid_reg <= 1'b1;
                        lat_cnt_reg   <= `LAT_CNT_RST;
                        // Reserved bits 15..3 are dropped from the address
                        word_addr_reg <= {ca_shift_reg[`CA_ROW_HI-`BYTE_WIDTH:`CA_ROW_LO-`BYTE_WIDTH],
                                          dq_s[`CA_COL_HI:`CA_COL_LO]};
                        state_reg     <= ST_LAT;
                     end
                  end
               end
               ST_LAT: begin
                  // Last latency clock ends on its fall; data starts at the next rise
                  if (lat_cnt_reg == lat_target_reg &&
                      (lat_target_reg == `LAT_CNT_RST || ck_fall)) begin
                     state_reg <= data_read ? ST_READ : ST_WRITE;
                     // Line turns to a mask input for writes
                     smask_oe_reg  <= data_read;
                     smask_out_reg <= 1'b0;
                     dq_oe_reg     <= data_read;
                  end else if (ck_rise) begin
                     lat_cnt_reg <= lat_cnt_reg + `ONE_LAT;
                  end
               end
               ST_READ: begin
                  if (ck_rise) begin
                     // An empty buffer repeats the last word rather than stall the bus
                     if (rd_buf_valid) begin
                        rd_hold_reg <= rd_buf_data;
                        dq_out_reg  <= rd_buf_data[`WORD_WIDTH-1:`BYTE_WIDTH];
                        rd_pop_reg  <= 1'b1;
                     end else begin
                        dq_out_reg  <= rd_hold_reg[`WORD_WIDTH-1:`BYTE_WIDTH];
                     end
                     smask_out_reg <= 1'b1;
                     word_addr_reg <= addr_next;
                     if (ca_hold_reg[`CA_BURST_BIT] &&
                         word_addr_reg[`COL_WIDTH-1:0] == `HALF_PAGE_LAST) begin
                        page_fetch_reg <= 1'b1;
                     end
                  end else if (ck_fall) begin
                     dq_out_reg    <= rd_hold_reg[`BYTE_WIDTH-1:0];
                     smask_out_reg <= 1'b0;
                  end
               end
               ST_WRITE: begin
                  if (ck_rise) begin
                     byte_a_reg <= dq_s;
                     mask_a_reg <= mask_s;
                  end else if (ck_fall) begin
                     // Byte enable is the inverse of the mask level
                     wr_word_reg   <= {byte_a_reg, dq_s, ~mask_a_reg, ~mask_s, word_addr_reg};
                     wr_push_reg   <= 1'b1;
                     word_addr_reg <= addr_next;
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ********************************
   // Outputs
   // ********************************
   assign dq_out               = dq_out_reg;
   assign dq_oe                = dq_oe_reg;
   assign strobe_mask_line_out = smask_out_reg;
   assign strobe_mask_line_oe  = smask_oe_reg;
   assign cmd_addr_bits        = ca_hold_reg;
   assign cmd_valid            = cmd_valid_reg;
   assign access_start         = access_start_reg;
   assign is_read              = ca_hold_reg[`CA_RW_BIT];
   assign space_select_bit     = ca_hold_reg[`CA_SPACE_BIT];
   assign linear_burst         = ca_hold_reg[`CA_BURST_BIT];
   assign row_upper_addr       = ca_hold_reg[`CA_ROW_HI:`CA_ROW_LO];
   assign start_word           = ca_hold_reg[`CA_COL_HI:`CA_COL_LO];
   assign word_addr            = word_addr_reg;
   assign page_fetch           = page_fetch_reg;
   assign frame_active         = ~state_reg[0];
   assign wr_overrun           = wr_overrun_reg;
endmodule // ddr_bus_cmd_addr_frontend

// ===== src/ddr_frontend_consts.vh
/*
  Constants for the DDR byte-wide bus front end: command/address field positions,
  counts and reset values. Included by every design file. It holds definitions only.
*/
`ifndef DDR_FRONTEND_CONSTS_VH
`define DDR_FRONTEND_CONSTS_VH

// ********************************
// Command/address layout
// ********************************
`define CA_WIDTH        48
`define CA_BYTE_COUNT   3'h6
`define CA_ROW_DONE     3'h4
`define CA_RW_BIT       47
`define CA_SPACE_BIT    46
`define CA_BURST_BIT    45
`define CA_ROW_HI       44
`define CA_ROW_LO       16
`define CA_COL_HI       2
`define CA_COL_LO       0
`define ROW_WIDTH       29
`define COL_WIDTH       3
`define ADDR_WIDTH      32

// ********************************
// Data path
// ********************************
`define BYTE_WIDTH      8
`define WORD_WIDTH      16
`define HALF_PAGE_LAST  3'h7
`define PIN_SYNC_WIDTH  13
`define LAT_WIDTH       4
`define LAT_CNT_WIDTH   5

// ********************************
// Reset values and increments
// ********************************
`define BYTE_RST        8'h00
`define WORD_RST        16'h0000
`define ADDR_RST        32'h00000000
`define CA_RST          48'h000000000000
`define LAT_CNT_RST     5'h00
`define EDGE_CNT_RST    3'h0
`define ONE_ADDR        32'h00000001
`define ONE_LAT         5'h01
`define ONE_EDGE        3'h1

`endif

// ===== src/pin_sync.v
/*
  Two flip-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a level that changes slowly against clk; no bus coherence.
*/
`timescale 1ns/1ps
`include "ddr_frontend_consts.vh"

module pin_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] level_out
);
   // ********************************
   // Synchroniser stages
   // ********************************
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // First stage feeds only the second
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   assign level_out = sync_reg;
endmodule // pin_sync

// ===== src/two_entry_buffer.v
/*
  Two-entry first-in first-out buffer with valid and ready on both sides.
  Assumes one clock; the ready and valid outputs are registered flags.
*/
`timescale 1ns/1ps
`include "ddr_frontend_consts.vh"

module two_entry_buffer #(
   parameter W = 16
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   // ********************************
   // Storage and pointers
   // ********************************
   reg [W-1:0] mem [0:1];
   reg         wr_ptr_reg;
   reg         rd_ptr_reg;
   reg [1:0]   count_reg;
   reg         in_ready_reg;
   reg         out_valid_reg;
   wire        push;
   wire        pop;
   reg [1:0]   count_next;

   assign push = in_valid & in_ready_reg;
   assign pop  = out_valid_reg & out_ready;

   always @* begin
      count_next = count_reg;
      if (push & ~pop) begin
         count_next = count_reg + 2'h1;
      end else if (pop & ~push) begin
         count_next = count_reg - 2'h1;
      end
   end

   // Flags registered so the ready seen by the source is glitch free
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_reg    <= 1'b0;
         rd_ptr_reg    <= 1'b0;
         count_reg     <= 2'h0;
         // Ready low in reset: a word offered then would be lost
         in_ready_reg  <= 1'b0;
         out_valid_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg     <= count_next;
         in_ready_reg  <= (count_next != 2'h2);
         out_valid_reg <= (count_next != 2'h0);
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   assign in_ready  = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data  = mem[rd_ptr_reg];
endmodule // two_entry_buffer

// ===== testbench/fe_sva.sv
/* Port checker for the DDR bus front end.
   Assumes a bench bus clock far slower than clk. */
`timescale 1ns/1ps
module fe_sva (
   input wire        clk,
   input wire        rst_n,
   input wire        chip_select_n,
   input wire        hw_reset_n,
   input wire        refresh_pending,
   input wire        dq_oe,
   input wire        strobe_mask_line_out,
   input wire        strobe_mask_line_oe,
   input wire [47:0] cmd_addr_bits,
   input wire        cmd_valid,
   input wire        access_start,
   input wire        is_read,
   input wire        space_select_bit,
   input wire        linear_burst,
   input wire [28:0] row_upper_addr,
   input wire [2:0]  start_word,
   input wire [31:0] word_addr,
   input wire        frame_active
);
   // *****
   // Assertions
   // *****
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Five cycles cover the pin synchroniser lag
   a_cs_release: assert property (chip_select_n [*5] |-> !dq_oe && !strobe_mask_line_oe && !frame_active)
      else $error("pins driven with select high");
   a_hw_reset_hiz: assert property (!hw_reset_n [*5] |-> !dq_oe && !strobe_mask_line_oe)
      else $error("pins driven in reset");
   a_ca_strobe: assert property (access_start |-> strobe_mask_line_oe && strobe_mask_line_out == refresh_pending)
      else $error("latency flag wrong");
   a_edge_order: assert property (access_start |-> ##[4:16] cmd_valid)
      else $error("command not complete");
   a_read_bit: assert property (cmd_valid |-> is_read == cmd_addr_bits[47])
      else $error("direction decode");
   a_space_bit: assert property (cmd_valid |-> space_select_bit == cmd_addr_bits[46])
      else $error("space decode");
   a_burst_bit: assert property (cmd_valid |-> linear_burst == cmd_addr_bits[45])
      else $error("burst decode");
   a_addr_fields: assert property (cmd_valid |-> row_upper_addr == cmd_addr_bits[44:16] && start_word == cmd_addr_bits[2:0]
      && word_addr == {cmd_addr_bits[44:16], cmd_addr_bits[2:0]})
      else $error("address decode");
endmodule // fe_sva
bind ddr_bus_cmd_addr_frontend fe_sva chk (.*);

// ===== testbench/host_model.sv
/* Host controller model: select, bus clock, bytes and mask.
   Assumes the bench resolves the shared lines. */
`timescale 1ns/1ps
module host_model (
   output reg       chip_select_n,
   output reg       bus_clock_true,
   output wire      bus_clock_comp,
   output reg [7:0] host_dq,
   output reg       host_mask,
   output reg       host_mask_oe,
   input wire [7:0] dq_in,
   input wire       strobe_mask_line_in
);
   reg [8:0] rd_q [$];
   integer   e, d, w, tot;
   assign bus_clock_comp = ~bus_clock_true;
   initial begin
      chip_select_n = 1'b1;
      bus_clock_true = 1'b0;
      host_dq = 8'h00;
      host_mask = 1'b0;
      host_mask_oe = 1'b0;
   end
   // *****
   // One frame; stop cuts it after that many edges
   // *****
   task frame(input [47:0] ca, input integer lat, input integer n, input [1:0] msk, input integer stop);
      begin
         d = 6 + 2 * lat;
         tot = d + 2 * n + ((ca[47] && n > 0) ? 2 : 0);
         chip_select_n = 1'b0;
         #64;
         for (e = 0; e < tot && e != stop; e = e + 1) begin
            w = e - d;
            host_mask_oe = !ca[47] && e >= d;
            host_dq = e < 6 ? ca[47 - 8 * e -: 8] : host_mask_oe ? {3'b101, e[0], w[4:1]} : ~host_dq;
            host_mask = host_mask_oe ? (w < 2) & msk[~e[0]] : ~host_mask;
            #16 bus_clock_true = ~bus_clock_true;
            #16;
            // Byte of the previous edge, sampled mid half-cycle
            if (ca[47] && w > 0 && w <= 2 * n) rd_q.push_back({strobe_mask_line_in, dq_in});
         end
         host_mask_oe = 1'b0;
         #64 chip_select_n = 1'b1;
         #64 bus_clock_true = 1'b0;
         #64;
      end
   endtask
endmodule // host_model

// ===== testbench/tb.sv
/* Self-checking bench for the DDR bus front end.
   Assumes fe_sva and host_model compiled first. */
`timescale 1ns/1ps
module tb;
   reg          clk, rst_n, hw_reset_n, diff_clock_en, refresh_pending, rd_valid, wr_ready, acc;
   reg  [3:0]   latency_count;
   reg  [15:0]  rd_word, w;
   reg  [82:0]  rows [0:2];
   integer      mismatches, n_tests, cvn, pfn, i, k;
   wire         chip_select_n, bus_clock_true, bus_clock_comp, host_mask, host_mask_oe;
   wire [7:0]   host_dq, dq_out;
   wire         dq_oe, strobe_mask_line_out, strobe_mask_line_oe, cmd_valid, access_start, is_read;
   wire         space_select_bit, linear_burst, page_fetch, frame_active, rd_ready, wr_valid, wr_overrun;
   wire [47:0]  cmd_addr_bits;
   wire [28:0]  row_upper_addr;
   wire [2:0]   start_word;
   wire [31:0]  word_addr, wr_addr;
   wire [15:0]  wr_word;
   wire [1:0]   wr_byte_en;
   wire [7:0]   dq_in = dq_oe ? dq_out : host_dq;
   wire         strobe_mask_line_in = strobe_mask_line_oe ? strobe_mask_line_out : host_mask;
   ddr_bus_cmd_addr_frontend uut (.*);
   host_model host (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #300000;
      mismatches = mismatches + 1;
      results;
   end
   always @(posedge clk) acc <= rd_valid & rd_ready;
   always @(negedge clk) if (acc) rd_word <= rd_word + 16'h0111;
   always @(posedge clk) if (cmd_valid) cvn <= cvn + 1;
   always @(posedge clk) if (page_fetch) pfn <= pfn + 1;
   task ck(input ok);
      begin
         n_tests = n_tests + 1;
         if (ok !== 1'b1) begin
            mismatches = mismatches + 1;
            $display("BAD %0t check %0d", $time, n_tests);
         end
      end
   endtask
   task results;
      begin
         if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // *****
   // Sequence
   // *****
   initial begin
      {rst_n, wr_ready, refresh_pending, acc} = 4'h0;
      {hw_reset_n, diff_clock_en, rd_valid} = 3'h7;
      latency_count = 4'h0;
      rd_word = 16'h1234;
      {mismatches, n_tests, cvn, pfn} = 0;
      // Reserved bits set on purpose in the first row
      rows[0] = {48'ha000_1234_fffa, 3'b101, 32'h0000_91a2};
      rows[1] = {48'h5fff_ffff_0007, 3'b010, 32'hffff_ffff};
      rows[2] = {48'he000_0001_0005, 3'b111, 32'h0000_000d};
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      ck(dq_oe === 1'b0 && strobe_mask_line_oe === 1'b0 && frame_active === 1'b0);
      for (i = 0; i < 3; i = i + 1) begin
         host.frame(rows[i][82:35], 0, 0, 2'b00, 99);
         ck(cmd_addr_bits === rows[i][82:35]);
         ck({is_read, space_select_bit, linear_burst} === rows[i][34:32]);
         ck({row_upper_addr, start_word} === rows[i][31:0] && word_addr === rows[i][31:0]);
      end
      ck(cvn === 3);
      {diff_clock_en, refresh_pending, latency_count} = 6'h11;
      host.frame(48'ha000_0002_0006, 2, 3, 2'b00, 99);
      ck(pfn === 1);
      ck(host.rd_q.size() === 6);
      for (i = 0; i < 6; i = i + 1) begin
         w = 16'h1234 + 16'h0111 * i[2:1];
         ck(host.rd_q[i] === {~i[0], i[0] ? w[7:0] : w[15:8]});
      end
      refresh_pending = 1'b0;
      host.frame(48'h2000_0010_0003, 1, 3, 2'b01, 99);
      ck(wr_overrun === 1'b1);
      @(negedge clk) wr_ready = 1'b1;
      k = 0;
      // Word shown at a falling edge is taken at the next rising edge
      repeat (10) begin
         if (wr_valid === 1'b1) begin
            ck(wr_word === {8'ha0 + k[7:0], 8'hb0 + k[7:0]} && wr_addr === 32'h83 + k);
            ck(wr_byte_en === (k == 0 ? 2'b10 : 2'b11));
            k = k + 1;
         end
         @(negedge clk);
      end
      ck(k === 2);
      k = cvn;
      host.frame(48'h8000_0000_0000, 0, 0, 2'b00, 3);
      ck(cvn === k && frame_active === 1'b0);
      fork
         host.frame(48'ha000_0000_0000, 1, 4, 2'b00, 99);
         begin
            repeat (55) @(negedge clk);
            hw_reset_n = 1'b0;
            repeat (5) @(negedge clk);
            ck(dq_oe === 1'b0 && strobe_mask_line_oe === 1'b0 && frame_active === 1'b0);
            hw_reset_n = 1'b1;
         end
      join
      results;
   end
endmodule // tb
